// file: include/fdi_pkg.sv
// shared types and constants of the floppy drive signal interface
package fdi_pkg;

    // ==============================================================
    // timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STEP_PULSE_NS = 3000;
    localparam int unsigned STEP_PULSE_CYC =
        (STEP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STEP_GAP_NS = 3000;
    localparam int unsigned STEP_GAP_CYC =
        (STEP_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W = 16;

    // ==============================================================
    // drive count and density codes
    localparam int unsigned NUM_DRIVES = 2;
    localparam logic [1:0] DENS_RESET = 2'h0;

    // ==============================================================
    // media-change status byte as software sees it
    localparam logic [11:0] DIR_ADDR = 12'h3f7;
    localparam int unsigned DIR_MEDIA_BIT = 7;

    // ==============================================================
    // seek direction levels
    localparam logic DIR_OUTWARD = 1'b1;
    localparam logic DIR_INWARD = 1'b0;
    // head side levels
    localparam logic SIDE0_LEVEL = 1'b1;
    localparam logic SIDE1_LEVEL = 1'b0;

    // ==============================================================
    // synchronised drive status bundle (active high)
    typedef struct packed {
        logic media_changed;
        logic write_protected;
        logic at_track_zero;
        logic at_track_start;
    } fdi_status_s;

    // drive control request bundle from the controller core
    typedef struct packed {
        logic [NUM_DRIVES-1:0] select;
        logic [NUM_DRIVES-1:0] motor_on;
        logic side1;
        logic [1:0] density;
    } fdi_ctrl_s;

    // stepper states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PULSE = 3'b010,
        ST_GAP = 3'b100
    } fdi_step_e;

endpackage : fdi_pkg

// file: rtl/fdi_sync.sv
// two flip-flop synchroniser for asynchronous drive inputs
`timescale 1ns/100ps
module fdi_sync #(
    parameter int unsigned WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ==============================================================
    // first stage read only by second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule : fdi_sync

// file: rtl/fdi_drive_if.sv
// drive-side signalling of the floppy controller
//
// Overview of operation
// [R01] head side output is high for side 0 and low for side 1.
// [R02] seek direction output is high for outward and low for inward.
// [R03] each commanded track step gives exactly one low pulse on the step output.
// [R04] the media change input is shown inverted as bit 7 of the status byte at 3f7.
// [R05] the drive raises media change when its door opened or the disk may have changed.
// [R06] two active-low open-drain select outputs pick drive 0 or drive 1.
// [R07] two active-low open-drain motor outputs run the spindle of drive 0 or 1.
// [R08] two density outputs show the drive and media type from configuration.
// [R09] while write protect is sensed, write commands are refused and nothing is written.
// [R10] the drive signals track zero low while the head is over the outermost track.
// [R11] the drive signals track start low when the index hole passes.
// [R12] write gate goes low just before writing begins.
// [R13] each flux transition to record gives one falling edge on the write data output.
// [R14] the drive delivers read data with one falling edge per flux transition.
// [R15] all asynchronous drive status inputs are synchronised before use.
`timescale 1ns/100ps
module fdi_drive_if #(
    parameter int unsigned STEP_CYC = fdi_pkg::STEP_PULSE_CYC,
    parameter int unsigned GAP_CYC = fdi_pkg::STEP_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // controller core side
    input wire fdi_pkg::fdi_ctrl_s ctrl,
    input wire logic step_req,
    input wire logic step_outward,
    output logic step_ready,
    output logic step_done,
    input wire logic write_req,
    input wire logic write_flux,
    output logic write_active,
    output logic write_refused,
    output fdi_pkg::fdi_status_s status,
    output logic [7:0] dir_byte,
    output logic read_flux_edge,
    // drive pins
    output logic head_side_select_n,
    output logic seek_direction_n,
    output logic seek_step_pulse_n,
    output logic seek_step_pulse_oe,
    output logic [fdi_pkg::NUM_DRIVES-1:0] drive_select_n,
    output logic [fdi_pkg::NUM_DRIVES-1:0] drive_select_oe,
    output logic [fdi_pkg::NUM_DRIVES-1:0] spindle_motor_on_n,
    output logic [fdi_pkg::NUM_DRIVES-1:0] spindle_motor_on_oe,
    output logic density_out_a,
    output logic density_out_b,
    output logic write_head_gate_n,
    output logic write_head_gate_oe,
    output logic write_flux_out_n,
    output logic write_flux_out_oe,
    input wire logic media_change_sense_n,
    input wire logic write_protect_sense_n,
    input wire logic outermost_track_sense_n,
    input wire logic track_start_pulse_n,
    input wire logic read_flux_in_n
);

    // refuse step timing that the counter cannot hold
    if (STEP_CYC < 1 || STEP_CYC >= (1 << fdi_pkg::CNT_W) ||
        GAP_CYC < 1 || GAP_CYC >= (1 << fdi_pkg::CNT_W))
    begin : g_bad_timing
        $error("step timing out of counter range");
    end

    // ==============================================================
    // input synchronisers
    logic [4:0] raw_in;
    logic [4:0] sync_in;

    assign raw_in = {media_change_sense_n, write_protect_sense_n,
                     outermost_track_sense_n, track_start_pulse_n, read_flux_in_n};

    fdi_sync #(.WIDTH(5), .RESET_VAL(5'h1f)) u_sync (
        .clk(clk),
        .rst(rst),
        .din(raw_in),
        .dout(sync_in)
    ); // see [R15]

    // ==============================================================
    // status registers and read edge detect
    logic rd_prev_ff, nxt_rd_prev;
    logic rd_edge_ff, nxt_rd_edge;
    fdi_pkg::fdi_status_s status_ff, nxt_status;
    logic [7:0] dir_ff, nxt_dir;

    always_comb
    begin
        nxt_status.media_changed = ~sync_in[4];
        nxt_status.write_protected = ~sync_in[3];
        nxt_status.at_track_zero = ~sync_in[2]; // see [R10]
        nxt_status.at_track_start = ~sync_in[1]; // see [R11]
        nxt_dir = 8'h00;
        nxt_dir[fdi_pkg::DIR_MEDIA_BIT] = ~sync_in[4]; // see [R04]
        nxt_rd_prev = sync_in[0];
        nxt_rd_edge = rd_prev_ff & ~sync_in[0]; // see [R14]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_ff <= '0;
            dir_ff <= 8'h00;
            rd_prev_ff <= 1'b1;
            rd_edge_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            dir_ff <= nxt_dir;
            rd_prev_ff <= nxt_rd_prev;
            rd_edge_ff <= nxt_rd_edge;
        end
    end

    assign status = status_ff;
    assign dir_byte = dir_ff;
    assign read_flux_edge = rd_edge_ff;

    // ==============================================================
    // drive select, motor, side and density outputs
    logic [fdi_pkg::NUM_DRIVES-1:0] sel_ff, nxt_sel;
    logic [fdi_pkg::NUM_DRIVES-1:0] mtr_ff, nxt_mtr;
    logic side_ff, nxt_side;
    logic [1:0] dens_ff, nxt_dens;

    always_comb
    begin
        nxt_sel = ctrl.select;
        nxt_mtr = ctrl.motor_on;
        nxt_side = ctrl.side1 ? fdi_pkg::SIDE1_LEVEL : fdi_pkg::SIDE0_LEVEL; // see [R01]
        nxt_dens = ctrl.density; // see [R08]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_ff <= '0;
            mtr_ff <= '0;
            side_ff <= fdi_pkg::SIDE0_LEVEL;
            dens_ff <= fdi_pkg::DENS_RESET;
        end
        else
        begin
            sel_ff <= nxt_sel;
            mtr_ff <= nxt_mtr;
            side_ff <= nxt_side;
            dens_ff <= nxt_dens;
        end
    end

    // open-drain: pull low and enable while asserted
    genvar gi;
    generate
        for (gi = 0; gi < fdi_pkg::NUM_DRIVES; gi++)
        begin : g_drv
            assign drive_select_n[gi] = ~sel_ff[gi]; // see [R06]
            assign drive_select_oe[gi] = sel_ff[gi];
            assign spindle_motor_on_n[gi] = ~mtr_ff[gi]; // see [R07]
            assign spindle_motor_on_oe[gi] = mtr_ff[gi];
        end
    endgenerate

    assign head_side_select_n = side_ff;
    assign density_out_a = dens_ff[0];
    assign density_out_b = dens_ff[1];

    // ==============================================================
    // step sequencer
    fdi_pkg::fdi_step_e st_ff, nxt_st;
    logic [fdi_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic dir_lvl_ff, nxt_dir_lvl;
    logic done_ff, nxt_done;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_dir_lvl = dir_lvl_ff;
        nxt_done = 1'b0;
        unique case (st_ff)
            fdi_pkg::ST_IDLE:
            begin
                if (step_req)
                begin
                    nxt_dir_lvl = step_outward ? fdi_pkg::DIR_OUTWARD
                                               : fdi_pkg::DIR_INWARD; // see [R02]
                    nxt_cnt = fdi_pkg::CNT_W'(STEP_CYC - 1);
                    nxt_st = fdi_pkg::ST_PULSE; // see [R03]
                end
            end
            fdi_pkg::ST_PULSE:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_cnt = fdi_pkg::CNT_W'(GAP_CYC - 1);
                    nxt_st = fdi_pkg::ST_GAP;
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            fdi_pkg::ST_GAP:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_done = 1'b1;
                    nxt_st = fdi_pkg::ST_IDLE;
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            default:
                nxt_st = fdi_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= fdi_pkg::ST_IDLE;
            cnt_ff <= '0;
            dir_lvl_ff <= fdi_pkg::DIR_OUTWARD;
            done_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            dir_lvl_ff <= nxt_dir_lvl;
            done_ff <= nxt_done;
        end
    end

    assign step_ready = (st_ff == fdi_pkg::ST_IDLE);
    assign step_done = done_ff;
    assign seek_direction_n = dir_lvl_ff;
    assign seek_step_pulse_n = ~(st_ff == fdi_pkg::ST_PULSE); // see [R03]
    assign seek_step_pulse_oe = (st_ff == fdi_pkg::ST_PULSE);

    // ==============================================================
    // write gate and write data
    logic gate_ff, nxt_gate;
    logic wdata_ff, nxt_wdata;
    logic refused_ff, nxt_refused;

    always_comb
    begin
        nxt_gate = write_req & ~status_ff.write_protected; // see [R09]
        nxt_refused = write_req & status_ff.write_protected; // see [R09]
        nxt_wdata = gate_ff & write_flux; // see [R13]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate_ff <= 1'b0;
            wdata_ff <= 1'b0;
            refused_ff <= 1'b0;
        end
        else
        begin
            gate_ff <= nxt_gate;
            wdata_ff <= nxt_wdata;
            refused_ff <= nxt_refused;
        end
    end

    // gate leads first data edge by one cycle
    assign write_head_gate_n = ~gate_ff; // see [R12]
    assign write_head_gate_oe = gate_ff;
    assign write_flux_out_n = ~wdata_ff; // see [R13]
    assign write_flux_out_oe = wdata_ff;
    assign write_active = gate_ff;
    assign write_refused = refused_ff;

endmodule : fdi_drive_if

// file: verif/fdi_drive_if_assertions.sv
// concurrent checks on the drive signal interface ports
`timescale 1ns/100ps
module fdi_drive_if_assertions #(
    parameter int unsigned STEP_CYC = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire fdi_pkg::fdi_ctrl_s ctrl,
    input wire logic step_req,
    input wire logic step_outward,
    input wire logic step_ready,
    input wire logic write_req,
    input wire logic write_refused,
    input wire fdi_pkg::fdi_status_s status,
    input wire logic [7:0] dir_byte,
    input wire logic head_side_select_n,
    input wire logic seek_direction_n,
    input wire logic seek_step_pulse_n,
    input wire logic [fdi_pkg::NUM_DRIVES-1:0] drive_select_n,
    input wire logic write_head_gate_n,
    input wire logic media_change_sense_n,
    input wire logic write_protect_sense_n
);
    // ==========================================
    // step pulse length counter
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [15:0] low_cnt_ff;
    // counts low cycles of the step output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            low_cnt_ff <= 16'h0;
        else
            low_cnt_ff <= seek_step_pulse_n ? 16'h0 : low_cnt_ff + 16'h1;
    end
    sequence s_take;
        step_req && step_ready;
    endsequence
    property p_side;
        1 |=> head_side_select_n == !$past(ctrl.side1);
    endproperty
    property p_dsel;
        1 |=> drive_select_n == ~$past(ctrl.select);
    endproperty
    property p_step_start;
        s_take |=> !seek_step_pulse_n && seek_direction_n == $past(step_outward);
    endproperty
    property p_step_len;
        $rose(seek_step_pulse_n) |-> low_cnt_ff == STEP_CYC;
    endproperty
    property p_no_step;
        step_ready && !step_req |=> seek_step_pulse_n;
    endproperty
    property p_dir_hold;
        !step_ready |=> $stable(seek_direction_n);
    endproperty
    property p_gate;
        write_req && !status.write_protected |=> !write_head_gate_n;
    endproperty
    property p_wp;
        write_req && status.write_protected |=> write_head_gate_n && write_refused;
    endproperty
    property p_dir_byte;
        1 |-> dir_byte == {!$past(media_change_sense_n, 3), 7'h0};
    endproperty
    property p_sync;
        1 |-> status.write_protected == !$past(write_protect_sense_n, 3);
    endproperty
    a_side: assert property (p_side) else $error("side level wrong");
    a_dsel: assert property (p_dsel) else $error("select wrong");
    a_step_start: assert property (p_step_start) else $error("step start wrong");
    a_step_len: assert property (p_step_len) else $error("step width wrong");
    a_no_step: assert property (p_no_step) else $error("stray step");
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
    a_gate: assert property (p_gate) else $error("gate not on");
    a_wp: assert property (p_wp) else $error("protected write");
    a_dir_byte: assert property (p_dir_byte) else $error("status byte wrong");
    a_sync: assert property (p_sync) else $error("sync latency wrong");
endmodule : fdi_drive_if_assertions
bind fdi_drive_if fdi_drive_if_assertions #(.STEP_CYC(STEP_CYC)) chk_u (
    .clk(clk), .rst(rst), .ctrl(ctrl), .step_req(step_req), .step_outward(step_outward),
    .step_ready(step_ready), .write_req(write_req), .write_refused(write_refused),
    .status(status), .dir_byte(dir_byte), .head_side_select_n(head_side_select_n),
    .seek_direction_n(seek_direction_n), .seek_step_pulse_n(seek_step_pulse_n),
    .drive_select_n(drive_select_n), .write_head_gate_n(write_head_gate_n),
    .media_change_sense_n(media_change_sense_n),
    .write_protect_sense_n(write_protect_sense_n)
);

// file: verif/fdi_drive_model.sv
// behavioural floppy drive mechanism behind the drive pins
`timescale 1ns/100ps
module fdi_drive_model (
    input wire logic clk,
    input wire logic step_w,
    input wire logic dir_w,
    input wire logic sel_w,
    input wire logic door_open,
    input wire logic protect,
    output logic media_change_sense_n,
    output logic write_protect_sense_n,
    output logic outermost_track_sense_n,
    output logic track_start_pulse_n,
    output logic read_flux_in_n,
    output int track
);
    // ==========================================
    // head and media state
    bit step_q;
    bit changed;
    int rev;
    // one track per falling step edge, stops at track zero
    always @(posedge clk)
    begin
        step_q <= step_w;
        if (step_q && !step_w)
            track <= dir_w ? (track > 0 ? track - 1 : 0) : track + 1;
        if (door_open)
            changed <= 1'b1;
        else if (!sel_w)
            changed <= 1'b0;
        rev <= (rev + 1) % 64;
    end
    // sense lines seen by the controller
    assign media_change_sense_n = !(door_open || changed);
    assign write_protect_sense_n = !protect;
    assign outermost_track_sense_n = (track != 0);
    assign track_start_pulse_n = !(rev < 2);
    assign read_flux_in_n = rev[1];
endmodule : fdi_drive_model

// file: verif/testbench.sv
// self-checking bench of the drive signal interface
`timescale 1ns/100ps
module testbench;
    // ==========================================
    // signals and instances
    logic clk = 1'b0;
    logic rst = 1'b1;
    fdi_pkg::fdi_ctrl_s ctrl = '0;
    logic step_req = 1'b0;
    logic step_outward = 1'b0;
    logic write_req = 1'b0;
    logic write_flux = 1'b0;
    logic door_open = 1'b0;
    logic protect = 1'b0;
    logic rdy, done, wact, wref, rfe, hs_n, sd_n, st_n, st_oe, da, db, wg_n, wg_oe, wf_n, wf_oe;
    logic mc_n, wp_n, tz_n, ix_n, rd_n;
    logic [1:0] ds_n, ds_oe, mo_n, mo_oe;
    logic [7:0] dir_byte;
    fdi_pkg::fdi_status_s status;
    int track;
    int exp_trk;
    int n_idx;
    int mismatches;
    int n_tests;
    always #10 clk = ~clk;
    fdi_drive_if #(.STEP_CYC(2), .GAP_CYC(2)) dut_u (
        .clk(clk), .rst(rst), .ctrl(ctrl), .step_req(step_req), .step_outward(step_outward),
        .step_ready(rdy), .step_done(done), .write_req(write_req), .write_flux(write_flux),
        .write_active(wact), .write_refused(wref), .status(status), .dir_byte(dir_byte),
        .read_flux_edge(rfe), .head_side_select_n(hs_n), .seek_direction_n(sd_n),
        .seek_step_pulse_n(st_n), .seek_step_pulse_oe(st_oe), .drive_select_n(ds_n),
        .drive_select_oe(ds_oe), .spindle_motor_on_n(mo_n), .spindle_motor_on_oe(mo_oe),
        .density_out_a(da), .density_out_b(db), .write_head_gate_n(wg_n),
        .write_head_gate_oe(wg_oe), .write_flux_out_n(wf_n), .write_flux_out_oe(wf_oe),
        .media_change_sense_n(mc_n), .write_protect_sense_n(wp_n),
        .outermost_track_sense_n(tz_n), .track_start_pulse_n(ix_n), .read_flux_in_n(rd_n)
    );
    fdi_drive_model drv_u (
        .clk(clk), .step_w(st_oe ? st_n : 1'b1), .dir_w(sd_n),
        .sel_w(ds_oe[0] ? ds_n[0] : 1'b1), .door_open(door_open), .protect(protect),
        .media_change_sense_n(mc_n), .write_protect_sense_n(wp_n),
        .outermost_track_sense_n(tz_n), .track_start_pulse_n(ix_n),
        .read_flux_in_n(rd_n), .track(track)
    );
    // compare one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // expected head track after one step, clamped at track zero
    function automatic int next_track(input int t, input logic outward);
        return outward ? (t > 0 ? t - 1 : 0) : t + 1;
    endfunction : next_track
    // one step request, then wait for completion
    task automatic do_step(input logic outward);
        int n;
        @(posedge clk);
        step_req <= 1'b1;
        step_outward <= outward;
        @(posedge clk);
        step_req <= 1'b0;
        @(negedge clk);
        check({st_n, st_oe}, 2'h1);
        n = 0;
        while (done !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        check(n < 50, 1'b1);
        exp_trk = next_track(exp_trk, outward);
        repeat (4) @(negedge clk);
        check(track, exp_trk);
        check({sd_n, status.at_track_zero}, {outward, exp_trk == 0});
    endtask : do_step
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // main sequence
    initial
    begin
        void'($urandom(77));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            ctrl <= fdi_pkg::fdi_ctrl_s'(7'($urandom));
            @(posedge clk);
            @(negedge clk);
            check({hs_n, ds_n, ds_oe}, {~ctrl.side1, ~ctrl.select, ctrl.select});
            check({mo_n, mo_oe, db, da}, {~ctrl.motor_on, ctrl.motor_on, ctrl.density});
        end
        @(posedge clk);
        ctrl <= '0;
        exp_trk = 0;
        for (int i = 1 + $urandom % 5; i > 0; i--)
            do_step(1'b0);
        for (int i = exp_trk + 1; i > 0; i--)
            do_step(1'b1);
        @(posedge clk);
        write_req <= 1'b1;
        @(posedge clk);
        write_flux <= 1'b1;
        @(posedge clk);
        write_flux <= 1'b0;
        @(negedge clk);
        check({wg_n, wf_n, wact}, 3'h1);
        check({wg_oe, wf_oe}, 2'h3);
        @(posedge clk);
        write_req <= 1'b0;
        protect <= 1'b1;
        @(negedge clk);
        check(wf_n, 1'b1);
        repeat (5) @(posedge clk);
        write_req <= 1'b1;
        write_flux <= 1'b1;
        repeat (2) @(negedge clk);
        check({wg_n, wf_n, wref}, 3'h7);
        check({wg_oe, wf_oe}, 2'h0);
        @(posedge clk);
        write_req <= 1'b0;
        write_flux <= 1'b0;
        door_open <= 1'b1;
        repeat (5) @(negedge clk);
        check(dir_byte, 8'h80);
        check(status.media_changed, 1'b1);
        @(posedge clk);
        door_open <= 1'b0;
        repeat (5) @(negedge clk);
        check(dir_byte, 8'h80);
        @(posedge clk);
        ctrl.select <= 2'h1;
        repeat (6) @(negedge clk);
        check(dir_byte, 8'h00);
        check(status.media_changed, 1'b0);
        exp_trk = 0;
        n_idx = 0;
        repeat (64)
        begin
            @(negedge clk);
            exp_trk += rfe;
            n_idx += status.at_track_start;
        end
        check(exp_trk, 16);
        check(n_idx, 2);
        give_verdict();
    end
    // hang guard
    initial
    begin
        #200us;
        mismatches++;
        give_verdict();
    end
endmodule : testbench
